/* File: lfxo_pkg.sv */
// Purpose: shared constants for the low-frequency and external oscillator control
// Assumes: 8-bit special function register bus, 40 MHz system clock
// Notes:   field positions, codes and nominal timing live here; tune reset, tune step and settle count are lfxo_ctrl parameters
package lfxo_pkg;
    // Register addresses on the special function bus
    localparam logic [7:0] LFXO_ADDR_EXT     = 8'hb1;
    localparam logic [7:0] LFXO_ADDR_LF      = 8'he3;

    // Low-frequency control fields
    localparam int         LF_EN_BIT         = 7;
    localparam int         LF_RDY_BIT        = 6;
    localparam int         LF_TUNE_LSB       = 2;
    localparam int         LF_TUNE_W         = 4;
    localparam int         LF_DIV_LSB        = 0;
    localparam int         LF_DIV_W          = 2;
    localparam logic [1:0] LF_DIV8           = 2'h0;
    localparam logic [1:0] LF_DIV4           = 2'h1;
    localparam logic [1:0] LF_DIV2           = 2'h2;
    localparam logic [1:0] LF_DIV1           = 2'h3;
    localparam logic [1:0] LF_DIV_RESET      = 2'h0;

    // External control fields
    localparam int         EXT_RSVD_HI_BIT   = 7;
    localparam int         EXT_RSVD_LO_BIT   = 3;
    localparam int         EXT_MODE_LSB      = 4;
    localparam int         EXT_MODE_W        = 3;
    localparam int         EXT_FREQ_LSB      = 0;
    localparam int         EXT_FREQ_W        = 3;
    localparam logic [2:0] EXT_MODE_CMOS     = 3'h2;
    localparam logic [2:0] EXT_MODE_CMOS_D2  = 3'h3;
    localparam logic [2:0] EXT_MODE_RC       = 3'h4;
    localparam logic [2:0] EXT_MODE_CAP      = 3'h5;
    localparam logic [2:0] EXT_MODE_RESET    = 3'h0;
    localparam logic [2:0] EXT_FREQ_RESET    = 3'h0;

    // Timing: nominal oscillator rate and derived half period in system clocks
    localparam int         CLK_HZ            = 40000000;
    localparam int         LF_NOM_HZ         = 80000;
    localparam int         LF_HALF_CYC       = CLK_HZ / LF_NOM_HZ / 2;
    localparam int         LF_TUNE_MID       = 8;
    localparam int         PH_W              = 10;
    localparam int         HC_W              = 3;
    localparam logic [2:0] HC_LAST           = 3'h7;
endpackage

/* File: lfxo_ctrl.sv */
// Purpose: control and status for the internal low-frequency oscillator and the
//          external oscillator drive circuit, reached over the special function bus
// Assumes: analog cores are outside; the low-frequency core is stood in for by a
//          digital half-period counter on clk; external clock pin is asynchronous
// Notes:   read data appears one cycle after the address
// Function
// - The low-frequency oscillator is held stopped while its enable bit is 0 and runs while it is 1.
// - A read-only ready flag reads 1 once the oscillator has settled and 0 before.
// - Once set, ready clears only on device reset or on a write that changes the divider field.
// - A 4-bit fine-tune field in bits 5:2 runs from fastest at 0000b to slowest at 1111b.
// - The 2-bit divider in bits 1:0 divides by 8, 4, 2, 1 for codes 00, 01, 10, 11.
// - External mode in bits 6:4 is off for 00x, CMOS clock for 010, and 11x is reserved.
// - Bits 7 and 3 of the external control register read 0 and ignore writes.
// - A 3-bit frequency-control field in bits 2:0 holds eight codes 000 to 111.
// - When the external circuit runs in capacitor, RC or CMOS mode, it takes the clock pin.
// - The oscillator is nominally 80 kHz before its output divider.
`timescale 1ns/10ps
module lfxo_ctrl #(
    parameter logic [3:0] LF_TUNE_RESET   = 4'h8,
    parameter int         LF_TUNE_STEP    = 8,
    parameter int         LF_SETTLE_TICKS = 16
) (
    input  wire logic                               clk,
    input  wire logic                               srst,
    input  wire logic [7:0]                         sfr_addr,
    input  wire logic                               sfr_wr,
    input  wire logic [7:0]                         sfr_wdata,
    output logic      [7:0]                         sfr_rdata,
    input  wire logic                               external_clock_pin,
    output logic                                    lowfreq_osc_enable,
    output logic                                    lowfreq_osc_ready,
    output logic      [lfxo_pkg::LF_TUNE_W-1:0]     lowfreq_fine_tune,
    output logic      [lfxo_pkg::LF_DIV_W-1:0]      lowfreq_divider_select,
    output logic                                    lowfreq_clk_out,
    output logic      [lfxo_pkg::EXT_MODE_W-1:0]    external_osc_mode,
    output logic      [lfxo_pkg::EXT_FREQ_W-1:0]    external_freq_control,
    output logic                                    external_pin_claim,
    output logic                                    external_clk_out
);
    import lfxo_pkg::*;

    // Half period grows with the tune code: code 0 is fastest
    function automatic logic [PH_W-1:0] lf_half(input logic [LF_TUNE_W-1:0] tune);
        lf_half = PH_W'(LF_HALF_CYC + (int'(tune) - LF_TUNE_MID) * LF_TUNE_STEP);
    endfunction

    // Toggle mask per divider code, counted in half periods
    function automatic logic [HC_W-1:0] div_mask(input logic [LF_DIV_W-1:0] sel);
        case (sel)
            LF_DIV8: div_mask = 3'h7;
            LF_DIV4: div_mask = 3'h3;
            LF_DIV2: div_mask = 3'h1;
            default: div_mask = 3'h0;
        endcase
    endfunction

    function automatic logic ext_runs(input logic [EXT_MODE_W-1:0] m);
        ext_runs = (m == EXT_MODE_CMOS) || (m == EXT_MODE_CMOS_D2) ||
                   (m == EXT_MODE_RC) || (m == EXT_MODE_CAP);
    endfunction

    logic                  lf_en_q, lf_en_d;
    logic [LF_TUNE_W-1:0]  lf_tune_q, lf_tune_d;
    logic [LF_DIV_W-1:0]   lf_div_q, lf_div_d;
    logic [LF_DIV_W-1:0]   div_act_q, div_act_d;
    logic                  lf_rdy_q, lf_rdy_d;
    logic [7:0]            settle_q, settle_d;
    logic [PH_W-1:0]       ph_q, ph_d;
    logic [HC_W-1:0]       hc_q, hc_d;
    logic                  lf_out_q, lf_out_d;
    logic [EXT_MODE_W-1:0] ext_mode_q, ext_mode_d;
    logic [EXT_FREQ_W-1:0] ext_freq_q, ext_freq_d;
    logic                  ext_out_q, ext_out_d;
    logic                  pin_s1_q, pin_s2_q, pin_s3_q;
    logic [7:0]            rdata_q, rdata_d;
    logic                  wr_lf, wr_ext, div_chg, en_rise, tick, boundary, pin_rise;

    assign wr_lf    = sfr_wr && (sfr_addr == LFXO_ADDR_LF);
    assign wr_ext   = sfr_wr && (sfr_addr == LFXO_ADDR_EXT);
    assign div_chg  = wr_lf && (sfr_wdata[LF_DIV_LSB +: LF_DIV_W] != lf_div_q);
    assign en_rise  = wr_lf && sfr_wdata[LF_EN_BIT] && !lf_en_q;
    // At or past the end, so a faster tune code never overruns the count
    assign tick     = lf_en_q && (ph_q >= lf_half(lf_tune_q) - PH_W'(1));
    // Boundary where every divider ratio is about to fall low together
    assign boundary = tick && (hc_q == HC_LAST) && lf_out_q;
    assign pin_rise = pin_s2_q && !pin_s3_q;

    // Low-frequency oscillator stand-in, divider and ready flag
    always_comb begin
        lf_en_d   = lf_en_q;
        lf_tune_d = lf_tune_q;
        lf_div_d  = lf_div_q;
        div_act_d = div_act_q;
        lf_rdy_d  = lf_rdy_q;
        settle_d  = settle_q;
        ph_d      = ph_q;
        hc_d      = hc_q;
        lf_out_d  = lf_out_q;
        if (wr_lf) begin
            lf_en_d   = sfr_wdata[LF_EN_BIT];
            lf_tune_d = sfr_wdata[LF_TUNE_LSB +: LF_TUNE_W];
            lf_div_d  = sfr_wdata[LF_DIV_LSB +: LF_DIV_W];
        end
        if (!lf_en_q) begin
            ph_d     = '0;
            hc_d     = '0;
            lf_out_d = 1'b0;
            div_act_d = lf_div_d;
        end else if (tick) begin
            ph_d = '0;
            hc_d = hc_q + HC_W'(1);
            if ((hc_q & div_mask(div_act_q)) == div_mask(div_act_q)) begin
                lf_out_d = !lf_out_q;
            end
            if (boundary) begin
                div_act_d = lf_div_q;
                hc_d      = '0;
            end
            if (lf_en_q && settle_q < 8'(LF_SETTLE_TICKS)) begin
                settle_d = settle_q + 8'h01;
            end
            if (settle_q == 8'(LF_SETTLE_TICKS - 1)) begin
                lf_rdy_d = 1'b1;
            end
        end else begin
            ph_d = ph_q + PH_W'(1);
        end
        // Divider change wins over a coinciding settle, as the flag must restart
        if (div_chg || en_rise) begin
            settle_d = '0;
        end
        if (div_chg) begin
            lf_rdy_d = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            lf_en_q   <= 1'b0;
            lf_tune_q <= LF_TUNE_RESET;
            lf_div_q  <= LF_DIV_RESET;
            div_act_q <= LF_DIV_RESET;
            lf_rdy_q  <= 1'b0;
            settle_q  <= '0;
            ph_q      <= '0;
            hc_q      <= '0;
            lf_out_q  <= 1'b0;
        end else begin
            lf_en_q   <= lf_en_d;
            lf_tune_q <= lf_tune_d;
            lf_div_q  <= lf_div_d;
            div_act_q <= div_act_d;
            lf_rdy_q  <= lf_rdy_d;
            settle_q  <= settle_d;
            ph_q      <= ph_d;
            hc_q      <= hc_d;
            lf_out_q  <= lf_out_d;
        end
    end

    // External oscillator control and clock path
    always_comb begin
        ext_mode_d = ext_mode_q;
        ext_freq_d = ext_freq_q;
        ext_out_d  = 1'b0;
        if (wr_ext) begin
            ext_mode_d = sfr_wdata[EXT_MODE_LSB +: EXT_MODE_W];
            ext_freq_d = sfr_wdata[EXT_FREQ_LSB +: EXT_FREQ_W];
        end
        case (ext_mode_q)
            EXT_MODE_CMOS:    ext_out_d = pin_s2_q;
            EXT_MODE_CMOS_D2,
            EXT_MODE_RC,
            EXT_MODE_CAP:     ext_out_d = pin_rise ? !ext_out_q : ext_out_q;
            default:          ext_out_d = 1'b0;
        endcase
    end

    // Register read mux; unmapped addresses read zero
    always_comb begin
        case (sfr_addr)
            LFXO_ADDR_LF:  rdata_d = {lf_en_q, lf_rdy_q, lf_tune_q, lf_div_q};
            LFXO_ADDR_EXT: rdata_d = {1'b0, ext_mode_q, 1'b0, ext_freq_q};
            default:       rdata_d = 8'h00;
        endcase
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            ext_mode_q <= EXT_MODE_RESET;
            ext_freq_q <= EXT_FREQ_RESET;
            ext_out_q  <= 1'b0;
            // Pin idles high on its pull-up; a low start would fake an edge
            pin_s1_q   <= 1'b1;
            pin_s2_q   <= 1'b1;
            pin_s3_q   <= 1'b1;
            rdata_q    <= 8'h00;
        end else begin
            ext_mode_q <= ext_mode_d;
            ext_freq_q <= ext_freq_d;
            ext_out_q  <= ext_out_d;
            pin_s1_q   <= external_clock_pin;
            pin_s2_q   <= pin_s1_q;
            pin_s3_q   <= pin_s2_q;
            rdata_q    <= rdata_d;
        end
    end

    assign sfr_rdata              = rdata_q;
    assign lowfreq_osc_enable     = lf_en_q;
    assign lowfreq_osc_ready      = lf_rdy_q;
    assign lowfreq_fine_tune      = lf_tune_q;
    assign lowfreq_divider_select = lf_div_q;
    assign lowfreq_clk_out        = lf_out_q;
    assign external_osc_mode      = ext_mode_q;
    assign external_freq_control  = ext_freq_q;
    // Pin only claimed in a running mode; reserved codes leave it free
    assign external_pin_claim     = ext_runs(ext_mode_q);
    assign external_clk_out       = ext_out_q;

    property p_lf_stop;
        @(posedge clk) disable iff (srst) !lowfreq_osc_enable |=> !lowfreq_clk_out;
    endproperty
    a_lf_stop: assert property (p_lf_stop) else $error("lf output moved while off");

    property p_rdy_clr;
        @(posedge clk) disable iff (srst) div_chg |=> !lowfreq_osc_ready;
    endproperty
    a_rdy_clr: assert property (p_rdy_clr) else $error("ready kept over divider change");

    property p_rdy_hold;
        @(posedge clk) disable iff (srst) lowfreq_osc_ready && !div_chg |=> lowfreq_osc_ready;
    endproperty
    a_rdy_hold: assert property (p_rdy_hold) else $error("ready dropped without cause");

    property p_rdy_set;
        @(posedge clk) disable iff (srst)
            $rose(lowfreq_osc_ready) |-> $past(settle_q) == 8'(LF_SETTLE_TICKS - 1) && $past(tick);
    endproperty
    a_rdy_set: assert property (p_rdy_set) else $error("ready set before settling");

    property p_tune_wr;
        @(posedge clk) disable iff (srst)
            wr_lf |=> lowfreq_fine_tune == $past(sfr_wdata[LF_TUNE_LSB +: LF_TUNE_W]);
    endproperty
    a_tune_wr: assert property (p_tune_wr) else $error("tune field not stored");

    property p_div1;
        @(posedge clk) disable iff (srst)
            tick && div_act_q == LF_DIV1 |=> lowfreq_clk_out != $past(lowfreq_clk_out);
    endproperty
    a_div1: assert property (p_div1) else $error("divide by 1 missed a toggle");

    property p_div_glitch;
        @(posedge clk) disable iff (srst) lf_en_q && !boundary |=> $stable(div_act_q);
    endproperty
    a_div_glitch: assert property (p_div_glitch) else $error("divider switched off boundary");

    property p_rsvd;
        @(posedge clk) disable iff (srst)
            sfr_addr == LFXO_ADDR_EXT |=> !sfr_rdata[EXT_RSVD_HI_BIT] && !sfr_rdata[EXT_RSVD_LO_BIT];
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("unused external bits read nonzero");

    property p_mode_off;
        @(posedge clk) disable iff (srst)
            wr_ext && sfr_wdata[6:5] != 2'h1 && !sfr_wdata[6] |=> !external_pin_claim ##1 !external_clk_out;
    endproperty
    a_mode_off: assert property (p_mode_off) else $error("external circuit on in off mode");

    property p_div2;
        @(posedge clk) disable iff (srst)
            ext_mode_q == EXT_MODE_RC && pin_rise |=> external_clk_out != $past(external_clk_out);
    endproperty
    a_div2: assert property (p_div2) else $error("divide by 2 stage missed an edge");

    property p_claim;
        @(posedge clk) disable iff (srst)
            wr_ext && sfr_wdata[EXT_MODE_LSB +: EXT_MODE_W] == EXT_MODE_CAP |=> external_pin_claim;
    endproperty
    a_claim: assert property (p_claim) else $error("pin not claimed in capacitor mode");

    property p_freq;
        @(posedge clk) disable iff (srst)
            wr_ext |=> external_freq_control == $past(sfr_wdata[EXT_FREQ_LSB +: EXT_FREQ_W]);
    endproperty
    a_freq: assert property (p_freq) else $error("frequency code not stored");
endmodule

/* File: lfxo_cmos_src.sv */
// Purpose: behavioural CMOS clock source wired to the external clock pin
// Assumes: free of any phase relation to the system clock
// Notes:   pin rests high (weak pull-up) while the source is stopped
`timescale 1ns/10ps
module lfxo_cmos_src #(
    parameter realtime HALF_NS = 130.0
) (
    input  wire logic run,
    output logic      pin
);
    // Digital levels only: the pin is a digital input in CMOS mode
    initial begin
        pin = 1'b1;
        forever begin
            #(HALF_NS);
            pin = run ? ~pin : 1'b1;
        end
    end
endmodule

/* File: lfxo_ctrl_tb.sv */
// Purpose: self-checking bench for the oscillator control block
// Assumes: settle count shortened to 4 ticks to keep the run short
// Notes:   bus and reset inputs change on the falling edge only
`timescale 1ns/10ps
module lfxo_ctrl_tb;
    import lfxo_pkg::*;
    logic       clk = 1'b0;
    logic       srst = 1'b1;
    logic [7:0] sfr_addr = 8'h00;
    logic       sfr_wr = 1'b0;
    logic [7:0] sfr_wdata = 8'h00;
    logic [7:0] sfr_rdata;
    logic       ext_pin;
    logic       src_run = 1'b1;
    logic       lf_en, lf_rdy, lf_clk, claim, ext_clk;
    logic [3:0] tune;
    logic [1:0] div;
    logic [2:0] mode, freq;
    int         fails = 0;
    int         checked = 0;
    always #12.5 clk = ~clk;
    lfxo_cmos_src src_u (.run(src_run), .pin(ext_pin));
    lfxo_ctrl #(.LF_SETTLE_TICKS(4)) dut_u (
        .clk(clk), .srst(srst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
        .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .external_clock_pin(ext_pin),
        .lowfreq_osc_enable(lf_en), .lowfreq_osc_ready(lf_rdy),
        .lowfreq_fine_tune(tune), .lowfreq_divider_select(div),
        .lowfreq_clk_out(lf_clk), .external_osc_mode(mode),
        .external_freq_control(freq), .external_pin_claim(claim),
        .external_clk_out(ext_clk));
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic summarize;
        $display("checks %0d mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr = 1'b1;
        @(negedge clk);
        sfr_wr = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(negedge clk);
        sfr_addr = a;
        @(negedge clk);
        chk(16'(sfr_rdata), 16'(e));
    endtask
    // Rising edges of one output over a fixed span
    task automatic rises(input bit use_lf, input int cyc, output int n);
        logic prev;
        n = 0;
        prev = use_lf ? lf_clk : ext_clk;
        repeat (cyc) begin
            @(negedge clk);
            if (!prev && (use_lf ? lf_clk : ext_clk))
                n++;
            prev = use_lf ? lf_clk : ext_clk;
        end
    endtask
    // Cycles between two rising edges of the divided clock, bounded
    task automatic period(output int n);
        int k;
        n = 0;
        for (k = 0; k < 6000 && !(lf_clk === 1'b0); k++)
            @(negedge clk);
        for (k = 0; k < 6000 && !(lf_clk === 1'b1); k++)
            @(negedge clk);
        for (k = 0; k < 6000 && !(lf_clk === 1'b0); k++) begin
            @(negedge clk);
            n++;
        end
        for (k = 0; k < 6000 && !(lf_clk === 1'b1); k++) begin
            @(negedge clk);
            n++;
        end
    endtask
    function automatic int half(input int t);
        return LF_HALF_CYC + (t - 8) * 8;
    endfunction
    task automatic t_reset;
        rd(LFXO_ADDR_LF, 8'h20);
        rd(LFXO_ADDR_EXT, 8'h00);
        rd(8'h55, 8'h00);
    endtask
    task automatic t_external;
        int m, n;
        for (m = 0; m < 8; m++) begin
            wr(LFXO_ADDR_EXT, {1'b1, 3'(m), 1'b1, 3'(7 - m)});
            rd(LFXO_ADDR_EXT, {1'b0, 3'(m), 1'b0, 3'(7 - m)});
            chk(16'(freq), 16'(7 - m));
            chk(16'(mode), 16'(m));
            chk(16'(claim), 16'(m >= 2 && m <= 5));
            rises(1'b0, 104, n);
            if (m == 2)
                chk(16'(n >= 9 && n <= 11), 16'h1);
            else if (m >= 3 && m <= 5)
                chk(16'(n >= 4 && n <= 6), 16'h1);
            else
                chk(16'(n), 16'h0);
        end
    endtask
    task automatic t_lowfreq;
        int k, n;
        logic [1:0] d;
        wr(LFXO_ADDR_LF, 8'h83);
        chk(16'({lf_en, lf_rdy}), 16'h2);
        for (k = 0; k < 3000 && lf_rdy !== 1'b1; k++)
            @(negedge clk);
        chk(16'(k >= 3 * half(0) && k <= 5 * half(0)), 16'h1);
        rd(LFXO_ADDR_LF, 8'hc3);
        period(n);
        chk(16'(n), 16'(2 * half(0)));
        wr(LFXO_ADDR_LF, 8'hbf);
        chk(16'(lf_rdy), 16'h1);
        chk(16'({tune, div}), 16'h3f);
        period(n);
        period(n);
        chk(16'(n), 16'(2 * half(15)));
        for (k = 0; k < 3; k++) begin
            d = 2'(2 - k);
            wr(LFXO_ADDR_LF, {6'h2f, d});
            @(negedge clk);
            chk(16'(lf_rdy), 16'h0);
            chk(16'(div), 16'(d));
            // New ratio waits for the old one's boundary, at most eight half periods
            repeat (9 * half(15)) @(negedge clk);
            period(n);
            chk(16'(n), 16'(2 * half(15) * (8 >> d)));
        end
        wr(LFXO_ADDR_LF, 8'h3c);
        chk(16'(lf_en), 16'h0);
        chk(16'(lf_rdy), 16'h1);
        rises(1'b1, 5000, n);
        chk(16'(n), 16'h0);
    endtask
    // Ready must drop on a reset in mid-run, then everything reads as after power-up
    task automatic t_midreset;
        @(negedge clk);
        srst = 1'b1;
        repeat (2) @(negedge clk);
        srst = 1'b0;
        chk(16'(lf_rdy), 16'h0);
        t_reset();
    endtask
    // Tests need about 29500 cycles
    initial begin
        repeat (80000) @(posedge clk);
        fails++;
        summarize();
    end
    initial begin
        repeat (6) @(negedge clk);
        srst = 1'b0;
        t_reset();
        t_external();
        t_lowfreq();
        t_midreset();
        summarize();
    end
endmodule
